// file: src/ptg_pkg.sv
// package for the periodic tick generator: register map, fields, resets
// assumes a 32-bit apb slave with one aligned word per register
package ptg_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CLEAR_OFS  = 8'h08;
  localparam logic [7:0] IRQEN_OFS  = 8'h0C;
  localparam logic [7:0] COUNT_OFS  = 8'h10;

  // control register fields
  localparam int RATE_LSB  = 0;
  localparam int RATE_W    = 3;
  localparam int ACK_BIT   = 3;
  localparam int IRQE_BIT  = 4;
  localparam int TEN_BIT   = 5;

  // status and interrupt layout
  localparam int FLAG_BIT  = 0;
  localparam int EVT_W     = 1;

  // reset values
  localparam logic [2:0]  RATE_RST = 3'h0;
  localparam logic [31:0] ZERO32   = 32'h0000_0000;

  // counter chain width covers the largest divide ratio
  localparam int CNT_W = 15;

  // divide ratio minus one as a terminal count for each rate code
  function automatic logic [CNT_W-1:0] ptg_term(input logic [2:0] code);
    logic [CNT_W-1:0] t;
    t = 15'h0000;
    unique case (code)
      3'h0: t = 15'h7FFF; // 32768
      3'h1: t = 15'h1FFF; // 8192
      3'h2: t = 15'h07FF; // 2048
      3'h3: t = 15'h007F; // 128
      3'h4: t = 15'h003F; // 64
      3'h5: t = 15'h001F; // 32
      3'h6: t = 15'h000F; // 16
      3'h7: t = 15'h0007; // 8
    endcase
    return t;
  endfunction

endpackage

// file: src/ptg_tick_if.sv
// interface carrying the counter chain controls between top and core
// assumes both ends share clk_i of the top
`timescale 1ns/1ps
interface ptg_tick_if;
  logic       run;
  logic [2:0] rate;
  logic       tick;
  logic [14:0] count;
  modport top  (output run, output rate, input tick, input count);
  modport core (input run, input rate, output tick, output count);
endinterface

// file: src/ptg_chain.sv
// counter chain of the tick generator, clocked by the synchronised
// oscillator edge enable; assumes osc_rise_i is a one-cycle pulse
`timescale 1ns/1ps
module ptg_chain
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic osc_rise_i,
  ptg_tick_if.core  tif
);

  logic [14:0] cnt_r;
  logic        hit;

  // rollover at the selected terminal count
  assign hit = osc_rise_i && (cnt_r == ptg_pkg::ptg_term(tif.rate));

  // ---------------------------------------------------------------
  // chain
  // ---------------------------------------------------------------
  // held at zero while stopped, so re-enabling restarts the phase
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      cnt_r <= 15'h0000;
    else if (!tif.run)
      cnt_r <= 15'h0000;
    else if (hit)
      cnt_r <= 15'h0000;
    else if (osc_rise_i)
      cnt_r <= cnt_r + 15'h0001;
  end

  // tick is a combinational handshake pulse
  assign tif.tick  = tif.run && hit;
  assign tif.count = cnt_r;

endmodule

// file: src/ptg_top.sv
// periodic tick generator: divides the oscillator input into ticks
// assumes apb master on clk_i; oscillator_input is asynchronous and
// much slower than clk_i (at most a quarter of its rate)
//
// Function
// - the rate_select code picks a divide ratio from 32768 down to 8.
// - flag_ack_bit is write-only and always reads as zero.
// - writing one to flag_ack_bit clears tick_flag, zero does nothing.
// - tick_irq_enable gates the flag onto the interrupt request.
// - reset clears tick_irq_enable.
// - tick_enable runs the chain; clear holds the chain at zero.
// - clearing then setting tick_enable restarts the chain from zero.
// - reset clears tick_enable, leaving the chain at zero.
// - every chain rollover sets tick_flag.
// - with the enable set, the request stays until the flag is acked.
`timescale 1ns/1ps
module ptg_top
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        oscillator_input_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             irq_o
);

  // ---------------------------------------------------------------
  // oscillator synchroniser and edge detect
  // ---------------------------------------------------------------
  logic osc_meta_r;
  logic osc_sync_r;
  logic osc_last_r;
  logic osc_rise;

  // two flops before any logic; the edge detector reads the second and a third delay flop
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
      osc_last_r <= 1'b0;
    end
    else
    begin
      osc_meta_r <= oscillator_input_i;
      osc_sync_r <= osc_meta_r;
      osc_last_r <= osc_sync_r;
    end
  end

  assign osc_rise = osc_sync_r && !osc_last_r;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_clr;
  logic hit_irqe;
  logic hit_cnt;
  logic mapped;

  // zero wait states: access completes in the first access cycle
  assign wr_en    = psel_i && penable_i && pwrite_i;
  assign rd_en    = psel_i && penable_i && !pwrite_i;
  assign hit_ctrl = (paddr_i == ptg_pkg::CTRL_OFS);
  assign hit_stat = (paddr_i == ptg_pkg::STATUS_OFS);
  assign hit_clr  = (paddr_i == ptg_pkg::CLEAR_OFS);
  assign hit_irqe = (paddr_i == ptg_pkg::IRQEN_OFS);
  assign hit_cnt  = (paddr_i == ptg_pkg::COUNT_OFS);
  assign mapped   = hit_ctrl | hit_stat | hit_clr | hit_irqe | hit_cnt;
  assign pready_o = 1'b1;

  // unmapped addresses answer with an error and no side effect
  assign pslverr_o = psel_i && penable_i && !mapped;

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  logic [2:0] rate_select_r;
  logic       tick_irq_enable_r;
  logic       tick_enable_r;
  logic       ctrl_wr;
  logic       ack_wr;

  // only the low byte lane carries control bits
  assign ctrl_wr = wr_en && hit_ctrl && pstrb_i[0];

  // both enables clear on reset; rate may be changed any time, but a
  // change while running gives one irregular first period
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rate_select_r     <= ptg_pkg::RATE_RST;
      tick_irq_enable_r <= 1'b0;
      tick_enable_r     <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      rate_select_r     <= pwdata_i[ptg_pkg::RATE_LSB +: ptg_pkg::RATE_W];
      tick_irq_enable_r <= pwdata_i[ptg_pkg::IRQE_BIT];
      tick_enable_r     <= pwdata_i[ptg_pkg::TEN_BIT];
    end
  end

  // acknowledge is a write strobe only, nothing stores it
  assign ack_wr = ctrl_wr && pwdata_i[ptg_pkg::ACK_BIT];

  // ---------------------------------------------------------------
  // counter chain
  // ---------------------------------------------------------------
  ptg_tick_if tif ();

  assign tif.run  = tick_enable_r;
  assign tif.rate = rate_select_r;

  ptg_chain u_chain
  (
    .clk_i      (clk_i),
    .reset_i    (reset_i),
    .osc_rise_i (osc_rise),
    .tif        (tif)
  );

  // ---------------------------------------------------------------
  // flag and interrupt status
  // ---------------------------------------------------------------
  logic tick_flag_r;
  logic clr_wr;
  logic clr_flag;
  logic irq_mask_r;
  logic tick_flag_nxt;
  logic irq_mask_nxt;

  // write-one-to-clear register mirrors the status layout
  assign clr_wr   = wr_en && hit_clr && pstrb_i[0]
                    && pwdata_i[ptg_pkg::FLAG_BIT];
  assign clr_flag = ack_wr || clr_wr;

  // set wins over clear so a tick in the ack cycle is kept
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      tick_flag_r <= 1'b0;
    else if (tif.tick)
      tick_flag_r <= 1'b1;
    else if (clr_flag)
      tick_flag_r <= 1'b0;
  end

  // enable register of the status layout, mirrors tick_irq_enable
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      irq_mask_r <= 1'b0;
    else if (wr_en && hit_irqe && pstrb_i[0])
      irq_mask_r <= pwdata_i[ptg_pkg::FLAG_BIT];
    else if (ctrl_wr)
      irq_mask_r <= pwdata_i[ptg_pkg::IRQE_BIT];
  end

  // level request held until the flag is cleared
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      irq_o <= 1'b0;
    else
      irq_o <= tick_flag_nxt && irq_mask_nxt;
  end

  // next-state views so the request tracks the flag with no extra lag
  always_comb
  begin
    tick_flag_nxt = tick_flag_r;
    if (tif.tick)
      tick_flag_nxt = 1'b1;
    else if (clr_flag)
      tick_flag_nxt = 1'b0;
    irq_mask_nxt = irq_mask_r;
    if (wr_en && hit_irqe && pstrb_i[0])
      irq_mask_nxt = pwdata_i[ptg_pkg::FLAG_BIT];
    else if (ctrl_wr)
      irq_mask_nxt = pwdata_i[ptg_pkg::IRQE_BIT];
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;

  // ack position reads zero; clear register reads zero
  always_comb
  begin
    rd_mux = ptg_pkg::ZERO32;
    if (hit_ctrl)
    begin
      rd_mux[ptg_pkg::RATE_LSB +: ptg_pkg::RATE_W] = rate_select_r;
      rd_mux[ptg_pkg::ACK_BIT]  = 1'b0;
      rd_mux[ptg_pkg::IRQE_BIT] = irq_mask_r;
      rd_mux[ptg_pkg::TEN_BIT]  = tick_enable_r;
    end
    else if (hit_stat)
      rd_mux[ptg_pkg::FLAG_BIT] = tick_flag_r;
    else if (hit_irqe)
      rd_mux[ptg_pkg::FLAG_BIT] = irq_mask_r;
    else if (hit_cnt)
      rd_mux[14:0] = tif.count;
  end

  // read data registered in the setup cycle, valid in the access cycle
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      prdata_o <= ptg_pkg::ZERO32;
    else if (psel_i && !penable_i && !pwrite_i)
      prdata_o <= rd_mux;
  end

  logic unused_rd;
  assign unused_rd = rd_en & tick_irq_enable_r;

endmodule

// file: testbench/ptg_props.sv
// checker for the tick generator at the pins of ptg_top
// assumes zero wait apb; enables are mirrored from observed writes
`timescale 1ns/1ps
module ptg_props
(
  input wire logic        clk_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0]  pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        irq_o
);
  // ------------------
  // mirror and checks
  // ------------------
  logic acc, rd, wr, ack, ten_r, ie_r;
  // pready never drops, so every access cycle completes
  assign acc = psel_i && penable_i;
  assign rd = acc && !pwrite_i;
  assign wr = acc && pwrite_i && pstrb_i[0];
  assign ack = wr && (paddr_i == ptg_pkg::CTRL_OFS ? pwdata_i[3] :
               paddr_i == ptg_pkg::CLEAR_OFS && pwdata_i[0]);
  // enables as software last wrote them
  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
      {ten_r, ie_r} <= 2'h0;
    else if (wr && paddr_i == ptg_pkg::CTRL_OFS)
      {ten_r, ie_r} <= pwdata_i[5:4];
    else if (wr && paddr_i == ptg_pkg::IRQEN_OFS)
      ie_r <= pwdata_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ready_always_a: assert property (pready_o) else $error("pready low");
  unmapped_err_a: assert property (acc && paddr_i > ptg_pkg::COUNT_OFS
    |-> pslverr_o) else $error("no slave error");
  ack_reads0_a: assert property (
    rd && paddr_i == ptg_pkg::CTRL_OFS |-> !prdata_o[3])
    else $error("ack bit reads one");
  clear_reads0_a: assert property (
    rd && paddr_i == ptg_pkg::CLEAR_OFS |-> prdata_o == 32'h0000_0000)
    else $error("clear reads nonzero");
  reset_clears_a: assert property ($fell(reset_i) |-> !irq_o &&
    prdata_o == 32'h0000_0000) else $error("reset state wrong");
  stop_holds_a: assert property (rd && paddr_i == ptg_pkg::COUNT_OFS
    && !ten_r && !$past(ten_r) && !$past(ten_r, 3) && !$past(ten_r, 2)
    |-> prdata_o == 32'h0000_0000) else $error("count not held");
  irq_gated_a: assert property (irq_o |-> ie_r)
    else $error("irq while disabled");
  irq_holds_a: assert property ($fell(irq_o)
    |-> $past(ack) || !ie_r) else $error("irq dropped early");
  cover property (ack);
  cover property ($rose(irq_o));
  cover property (acc && pslverr_o);
endmodule
bind ptg_top ptg_props u_ptg_props (.clk_i(clk_i), .reset_i(reset_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .irq_o(irq_o));

// file: testbench/ptg_tb_top.sv
// self-checking bench for the tick generator: apb master and oscillator
// assumes ptg_top answers apb at once; oscillator runs at clk/4
`timescale 1ns/1ps
module ptg_tb_top;
  logic        clk_i, reset_i, osc_i, psel_i, penable_i, pwrite_i, serr;
  logic        pready_o, pslverr_o, irq_o;
  logic [7:0]  paddr_i;
  logic [3:0]  pstrb_i;
  logic [31:0] pwdata_i, prdata_o, rdat;
  int          mismatches, n_tests;
  int          nlim [8] = '{8192, 8192, 2048, 128, 64, 32, 16, 8};
  ptg_top u_ptg_top (.clk_i(clk_i), .reset_i(reset_i),
    .oscillator_input_i(osc_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_o(irq_o));
  // -------
  // tasks
  // -------
  task automatic results;
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // fresh edge first, so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1)
      @(posedge clk_i);
    rdat = prdata_o;
    serr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // n oscillator periods, then the synchroniser and flag latency
  task automatic osc(input int n);
    repeat (n)
    begin
      repeat (2) @(posedge clk_i);
      osc_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      osc_i <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
  endtask
  task automatic t_reset;
    rd(ptg_pkg::CTRL_OFS);
    chk("ctrl", 32'h0000_0000, rdat);
    rd(8'h40);
    chk("slverr", 32'h0000_0001, {31'h0, serr});
    chk("bad data", 32'h0000_0000, rdat);
  endtask
  // code 0 is only run for 8192 edges and must not tick yet
  task automatic t_rate(input logic [2:0] c);
    logic [31:0] v;
    logic        hit;
    hit = c != 3'h0;
    v = {26'h0, 1'b1, c != 3'h6, 1'b1, c};
    apb(1'b1, ptg_pkg::CTRL_OFS, v & 32'hFFFF_FFDF);
    rd(ptg_pkg::COUNT_OFS);
    chk("count held", 32'h0000_0000, rdat);
    apb(1'b1, ptg_pkg::CTRL_OFS, v);
    rd(ptg_pkg::CTRL_OFS);
    chk("ctrl", v & 32'hFFFF_FFF7, rdat);
    osc(nlim[c] - 1);
    rd(ptg_pkg::STATUS_OFS);
    chk("flag early", 32'h0000_0000, rdat);
    osc(1);
    rd(ptg_pkg::STATUS_OFS);
    chk("flag", {31'h0, hit}, rdat);
    chk("irq", {31'h0, hit && c != 3'h6}, {31'h0, irq_o});
    apb(1'b1, ptg_pkg::CLEAR_OFS, 32'h0000_0000);
    rd(ptg_pkg::STATUS_OFS);
    chk("flag kept", {31'h0, hit}, rdat);
    apb(1'b1, ptg_pkg::CLEAR_OFS, 32'h0000_0001);
    rd(ptg_pkg::STATUS_OFS);
    chk("flag clear", 32'h0000_0000, rdat);
    chk("irq clear", 32'h0000_0000, {31'h0, irq_o});
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // watchdog well past the longest expected run
  initial
  begin
    #1500000;
    mismatches++;
    results;
  end
  initial
  begin
    {reset_i, osc_i, psel_i, penable_i, pwrite_i} = 5'h10;
    paddr_i = 8'h00;
    pwdata_i = 32'h0000_0000;
    pstrb_i = 4'hF;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset;
    for (int c = 0; c < 8; c++)
      t_rate(c[2:0]);
    results;
  end
endmodule
